//--- verilog/sbsp_pkg.sv
// Constants, register map and state codes shared by both link ends.
// Assumes one 100 MHz system clock and an APB bus with 32-bit data.
package sbsp_pkg;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DATA   = 8'h08;
    localparam logic [7:0] OFS_PINS   = 8'h0c;
    localparam int CTRL_IRQ_EN  = 7;
    localparam int CTRL_ENABLE  = 6;
    localparam int CTRL_LSB     = 5;
    localparam int CTRL_CTRLSEL = 4;
    localparam int STAT_DONE    = 7;
    localparam int STAT_WCOL    = 6;
    localparam int PIN_MOSI_OUT = 0;
    localparam int PIN_SCK_OUT  = 1;
    localparam int PIN_SS_OUT   = 2;
    localparam int PIN_MISO_OUT = 3;
    localparam int PIN_SS_LEVEL = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] PINS_RESET = 5'h10;
    localparam int BITS_PER_BYTE = 8;
    localparam int CLK_MHZ       = 100;
    localparam int PARTNER_HALF_NS = 40;
    localparam int PARTNER_HALF_CYC = (PARTNER_HALF_NS * CLK_MHZ) / 1000;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } sbsp_state_e;
endpackage : sbsp_pkg

//--- verilog/sbsp_link_if.sv
// Serial link between the port and its partner; resolves shared wires.
// Assumes each end drives a pin only while its enable is high.
`timescale 1ns/100ps
`default_nettype none
interface sbsp_link_if;
    logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
    logic dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
    logic prt_sck_o, prt_sck_oe, prt_mosi_o, prt_mosi_oe;
    logic prt_miso_o, prt_miso_oe, prt_ss_o, prt_ss_oe;
    logic sck, mosi, miso, ss_n;
    // Idle levels: clock low, select high
    assign sck  = dev_sck_oe  ? dev_sck_o  : (prt_sck_oe  ? prt_sck_o  : 1'b0);
    assign mosi = dev_mosi_oe ? dev_mosi_o : (prt_mosi_oe ? prt_mosi_o : 1'b0);
    assign miso = dev_miso_oe ? dev_miso_o : (prt_miso_oe ? prt_miso_o : 1'b0);
    assign ss_n = dev_ss_oe   ? dev_ss_o   : (prt_ss_oe   ? prt_ss_o   : 1'b1);
    modport device (input sck, mosi, miso, ss_n,
                    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
                    output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe);
    modport partner (input sck, mosi, miso, ss_n,
                     output prt_sck_o, prt_sck_oe, prt_mosi_o, prt_mosi_oe,
                     output prt_miso_o, prt_miso_oe, prt_ss_o, prt_ss_oe);
endinterface : sbsp_link_if
`default_nettype wire

//--- verilog/sbsp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module sbsp_pin_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic s1_q, s2_q, s3_q, lvl_q;
    wire  agree = (s2_q == s3_q);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            lvl_q <= INIT;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) lvl_q <= s3_q;
        end
    end
    assign level_out = lvl_q;
    assign rise_out  = agree & s3_q & ~lvl_q;
    assign fall_out  = agree & ~s3_q & lvl_q;
endmodule : sbsp_pin_sync
`default_nettype wire

//--- verilog/sbsp_device_end.sv
// Byte shift port, controller or peripheral, with APB registers.
// Assumes APB master on CLOCK_IN; link wires resolved in sbsp_link_if.
`timescale 1ns/100ps
`default_nettype none
module sbsp_device_end (
    input  wire logic        CLOCK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             IRQ_OUT,
    output logic             WAKE_OUT,
    sbsp_link_if.device      link
);
    logic [7:0]  ctrl_q, sh_q, rx_q;
    logic [4:0]  pins_q;
    logic [3:0]  cnt_q;
    logic [6:0]  div_q;
    logic        done_q, wcol_q, sck_q, mosi_q, miso_q, irq_q, wake_q;
    logic [3:0]  oe_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    sbsp_pkg::sbsp_state_e st_q;

    logic ss_lvl, ss_rise, ss_fall, sck_rise, sck_fall, mosi_s, miso_s;
    sbsp_pin_sync #(.INIT(1'b1)) u_ss (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.ss_n), .level_out(ss_lvl), .rise_out(ss_rise), .fall_out(ss_fall));
    sbsp_pin_sync #(.INIT(1'b0)) u_sck (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.sck), .level_out(), .rise_out(sck_rise), .fall_out(sck_fall));
    sbsp_pin_sync #(.INIT(1'b0)) u_mosi (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.mosi), .level_out(mosi_s), .rise_out(), .fall_out());
    sbsp_pin_sync #(.INIT(1'b0)) u_miso (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.miso), .level_out(miso_s), .rise_out(), .fall_out());

    function automatic logic out_bit(input logic [7:0] v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction : out_bit
    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic lsb);
        shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shift_in
    // Half period reload; codes 6 and 7 share the slowest rate
    function automatic logic [6:0] half_reload(input logic [2:0] r);
        logic [2:0] e;
        e = (r == 3'h7) ? 3'h6 : r;
        half_reload = 7'((8'h01 << e) - 8'h01);
    endfunction : half_reload

    // Register access decode
    wire acc      = PSEL_IN & PENABLE_IN & pready_q;
    wire wr       = acc & PWRITE_IN;
    wire rd       = acc & ~PWRITE_IN;
    wire hit_ctrl = (PADDR_IN == sbsp_pkg::OFS_CTRL);
    wire hit_stat = (PADDR_IN == sbsp_pkg::OFS_STATUS);
    wire hit_data = (PADDR_IN == sbsp_pkg::OFS_DATA);
    wire hit_pins = (PADDR_IN == sbsp_pkg::OFS_PINS);
    wire mapped   = hit_ctrl | hit_stat | hit_data | hit_pins;

    wire enable   = ctrl_q[sbsp_pkg::CTRL_ENABLE];
    wire lsb      = ctrl_q[sbsp_pkg::CTRL_LSB];
    wire is_ctrl  = ctrl_q[sbsp_pkg::CTRL_CTRLSEL];
    wire ctrl_on  = enable & is_ctrl;
    wire per_on   = enable & ~is_ctrl;
    wire ss_act   = per_on & ~ss_lvl;
    wire busy     = (st_q == sbsp_pkg::ST_SHIFT) | (ss_act & (cnt_q != 4'h0));
    wire dat_wr   = wr & hit_data;
    wire dat_acc  = acc & hit_data;
    wire load     = dat_wr & ~busy & enable;
    wire fault    = ctrl_on & ~pins_q[sbsp_pkg::PIN_SS_OUT] & ~ss_lvl;
    wire tick     = (st_q == sbsp_pkg::ST_SHIFT) & (div_q == 7'h00);
    wire c_rise   = tick & ~sck_q;
    wire c_end    = tick & sck_q & (cnt_q == 4'(sbsp_pkg::BITS_PER_BYTE));
    wire p_samp   = ss_act & sck_rise;
    wire p_end    = p_samp & (cnt_q == 4'(sbsp_pkg::BITS_PER_BYTE - 1));
    wire [7:0] p_next = shift_in(sh_q, mosi_s, lsb);
    wire done_evt = c_end | p_end | fault;
    wire [31:0] rdata =
        hit_ctrl ? {24'h000000, ctrl_q} :
        hit_stat ? {24'h000000, done_q, wcol_q, 6'h00} :
        hit_data ? {24'h000000, rx_q} :
        hit_pins ? {27'h0000000, pins_q} : 32'h00000000;

    // APB slave: one wait state, error on unmapped address
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= PSEL_IN & PENABLE_IN & ~pready_q;
            pslverr_q <= PSEL_IN & PENABLE_IN & ~pready_q & ~mapped;
            if (PSEL_IN & PENABLE_IN & ~pready_q) prdata_q <= rdata;
        end
    end

    // Control, direction and flag registers
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q <= sbsp_pkg::CTRL_RESET;
            pins_q <= sbsp_pkg::PINS_RESET;
            done_q <= 1'b0;
            wcol_q <= 1'b0;
        end else begin
            if (wr & hit_ctrl) ctrl_q <= PWDATA_IN[7:0];
            if (fault) ctrl_q[sbsp_pkg::CTRL_CTRLSEL] <= 1'b0;
            if (wr & hit_pins) pins_q <= PWDATA_IN[4:0];
            if (done_evt) done_q <= 1'b1;
            else if (dat_acc) done_q <= 1'b0;
            if (dat_wr & busy) wcol_q <= 1'b1;
            else if (dat_acc) wcol_q <= 1'b0;
        end
    end

    // Shift engine, both roles
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            st_q   <= sbsp_pkg::ST_IDLE;
            sh_q   <= 8'h00;
            rx_q   <= 8'h00;
            cnt_q  <= 4'h0;
            div_q  <= 7'h00;
            sck_q  <= 1'b0;
            mosi_q <= 1'b0;
            miso_q <= 1'b0;
        end else if (!enable || fault) begin
            st_q  <= sbsp_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sck_q <= 1'b0;
        end else begin
            case (st_q)
                sbsp_pkg::ST_IDLE: begin
                    if (load) begin
                        sh_q   <= PWDATA_IN[7:0];
                        mosi_q <= out_bit(PWDATA_IN[7:0], lsb);
                        miso_q <= out_bit(PWDATA_IN[7:0], lsb);
                        if (is_ctrl) begin
                            st_q  <= sbsp_pkg::ST_SHIFT;
                            cnt_q <= 4'h0;
                            div_q <= half_reload(ctrl_q[2:0]);
                        end
                    end
                    if (!is_ctrl) begin
                        if (ss_rise) cnt_q <= 4'h0;
                        if (ss_fall || (ss_act && sck_fall)) miso_q <= out_bit(sh_q, lsb);
                        if (p_samp) begin
                            sh_q  <= p_next;
                            cnt_q <= p_end ? 4'h0 : cnt_q + 4'h1;
                            if (p_end) rx_q <= p_next;
                        end
                    end
                end
                sbsp_pkg::ST_SHIFT: begin
                    div_q <= (div_q == 7'h00) ? half_reload(ctrl_q[2:0]) : div_q - 7'h01;
                    if (tick && !c_end) sck_q <= ~sck_q;
                    if (c_rise) begin
                        sh_q  <= shift_in(sh_q, miso_s, lsb);
                        cnt_q <= cnt_q + 4'h1;
                    end else if (tick && !c_end) begin
                        mosi_q <= out_bit(sh_q, lsb);
                    end
                    if (c_end) begin
                        st_q  <= sbsp_pkg::ST_IDLE;
                        sck_q <= 1'b0;
                        rx_q  <= sh_q;
                    end
                end
                default: st_q <= sbsp_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin direction overrides and request outputs
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            oe_q   <= 4'h0;
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            oe_q[0] <= ctrl_on & ~fault & pins_q[sbsp_pkg::PIN_MOSI_OUT];
            oe_q[1] <= ctrl_on & ~fault & pins_q[sbsp_pkg::PIN_SCK_OUT];
            oe_q[2] <= ~per_on & pins_q[sbsp_pkg::PIN_SS_OUT];
            oe_q[3] <= ss_act & pins_q[sbsp_pkg::PIN_MISO_OUT];
            irq_q   <= (done_q | done_evt) & ctrl_q[sbsp_pkg::CTRL_IRQ_EN];
            wake_q  <= done_evt;
        end
    end

    assign link.dev_sck_o   = sck_q;
    assign link.dev_sck_oe  = oe_q[1];
    assign link.dev_mosi_o  = mosi_q;
    assign link.dev_mosi_oe = oe_q[0];
    assign link.dev_miso_o  = miso_q;
    assign link.dev_miso_oe = oe_q[3];
    assign link.dev_ss_o    = pins_q[sbsp_pkg::PIN_SS_LEVEL];
    assign link.dev_ss_oe   = oe_q[2];
    assign PRDATA_OUT  = prdata_q;
    assign PREADY_OUT  = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign IRQ_OUT     = irq_q;
    assign WAKE_OUT    = wake_q;
endmodule : sbsp_device_end
`default_nettype wire

//--- verilog/sbsp_partner_end.sv
// Far end of the link: simple controller or peripheral, plain user port.
// Assumes the same system clock; link wires resolved in sbsp_link_if.
`timescale 1ns/100ps
`default_nettype none
module sbsp_partner_end #(
    parameter int HALF_CYC = sbsp_pkg::PARTNER_HALF_CYC
) (
    input  wire logic       CLOCK_IN,
    input  wire logic       SYS_RST_IN,
    input  wire logic       CONTROLLER_ROLE_IN,
    input  wire logic       LSB_FIRST_IN,
    input  wire logic       START_IN,
    input  wire logic [7:0] TX_DATA_IN,
    input  wire logic       KEEP_SELECT_IN,
    output logic            BUSY_OUT,
    output logic            DONE_OUT,
    output logic [7:0]      RX_DATA_OUT,
    sbsp_link_if.partner    link
);
    logic [7:0] sh_q, rx_q;
    logic [3:0] cnt_q;
    logic [7:0] div_q;
    logic       sck_q, out_q, ss_q, done_q, busy_q;
    sbsp_pkg::sbsp_state_e st_q;
    logic ss_lvl, ss_fall, sck_rise, sck_fall, mosi_s, miso_s;

    sbsp_pin_sync #(.INIT(1'b1)) u_ss (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.ss_n), .level_out(ss_lvl), .rise_out(), .fall_out(ss_fall));
    sbsp_pin_sync #(.INIT(1'b0)) u_sck (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.sck), .level_out(), .rise_out(sck_rise), .fall_out(sck_fall));
    sbsp_pin_sync #(.INIT(1'b0)) u_mosi (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.mosi), .level_out(mosi_s), .rise_out(), .fall_out());
    sbsp_pin_sync #(.INIT(1'b0)) u_miso (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN),
        .pin_in(link.miso), .level_out(miso_s), .rise_out(), .fall_out());

    wire       ctl    = CONTROLLER_ROLE_IN;
    wire       idle   = (st_q == sbsp_pkg::ST_IDLE);
    wire       tick   = ~idle & (div_q == 8'h00);
    wire       in_bit = ctl ? miso_s : mosi_s;
    wire       samp   = ctl ? (tick & ~sck_q) : (~ss_lvl & sck_rise);
    wire [7:0] nxt    = LSB_FIRST_IN ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};
    wire       c_end  = tick & sck_q & (cnt_q == 4'(sbsp_pkg::BITS_PER_BYTE));
    wire       p_end  = ~ctl & samp & (cnt_q == 4'(sbsp_pkg::BITS_PER_BYTE - 1));
    wire       obit   = LSB_FIRST_IN ? sh_q[0] : sh_q[7];
    wire [7:0] half   = 8'(HALF_CYC - 1);

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            st_q   <= sbsp_pkg::ST_IDLE;
            sh_q   <= 8'h00;
            rx_q   <= 8'h00;
            cnt_q  <= 4'h0;
            div_q  <= 8'h00;
            sck_q  <= 1'b0;
            out_q  <= 1'b0;
            ss_q   <= 1'b1;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= c_end | p_end;
            busy_q <= ~idle & ~c_end;
            if (ctl) begin
                case (st_q)
                    sbsp_pkg::ST_IDLE: begin
                        if (START_IN) begin
                            st_q  <= sbsp_pkg::ST_SHIFT;
                            ss_q  <= 1'b0;
                            sh_q  <= TX_DATA_IN;
                            out_q <= LSB_FIRST_IN ? TX_DATA_IN[0] : TX_DATA_IN[7];
                            cnt_q <= 4'h0;
                            div_q <= half;
                        end
                    end
                    sbsp_pkg::ST_SHIFT: begin
                        div_q <= tick ? half : div_q - 8'h01;
                        if (tick && !c_end) sck_q <= ~sck_q;
                        if (samp) begin
                            sh_q  <= nxt;
                            cnt_q <= cnt_q + 4'h1;
                        end else if (tick && !c_end) begin
                            out_q <= obit;
                        end
                        if (c_end) begin
                            st_q  <= sbsp_pkg::ST_IDLE;
                            ss_q  <= KEEP_SELECT_IN ? 1'b0 : 1'b1;
                            rx_q  <= sh_q;
                            sck_q <= 1'b0;
                        end
                    end
                    default: st_q <= sbsp_pkg::ST_IDLE;
                endcase
            end else begin
                st_q  <= sbsp_pkg::ST_IDLE;
                ss_q  <= 1'b1;
                sck_q <= 1'b0;
                if (START_IN && (ss_lvl || cnt_q == 4'h0)) begin
                    sh_q  <= TX_DATA_IN;
                    out_q <= LSB_FIRST_IN ? TX_DATA_IN[0] : TX_DATA_IN[7];
                end else if (ss_fall || (!ss_lvl && sck_fall)) begin
                    out_q <= obit;
                end
                if (ss_lvl) cnt_q <= 4'h0;
                else if (samp) begin
                    sh_q  <= nxt;
                    cnt_q <= p_end ? 4'h0 : cnt_q + 4'h1;
                    if (p_end) rx_q <= nxt;
                end
            end
        end
    end

    assign link.prt_sck_o   = sck_q;
    assign link.prt_sck_oe  = ctl;
    assign link.prt_mosi_o  = out_q;
    assign link.prt_mosi_oe = ctl;
    assign link.prt_miso_o  = out_q;
    assign link.prt_miso_oe = ~ctl & ~ss_lvl;
    assign link.prt_ss_o    = ss_q;
    assign link.prt_ss_oe   = ctl;
    assign BUSY_OUT    = busy_q;
    assign DONE_OUT    = done_q;
    assign RX_DATA_OUT = rx_q;
endmodule : sbsp_partner_end
`default_nettype wire

//--- sim/sbsp_link_properties.sv
// Link checker: timing and drive rules on the resolved serial wires.
// Assumes one clock for both ends; instantiated beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module sbsp_link_properties (
    input  wire logic CLOCK_IN,
    input  wire logic SYS_RST_IN,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic ss_n,
    input  wire logic dev_sck_oe,
    input  wire logic dev_miso_oe,
    input  wire logic prt_sck_oe,
    input  wire logic prt_mosi_oe
);
    logic       sck_q;
    logic [4:0] idle_q;
    logic [3:0] rises_q;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Clock rises per burst; a burst ends after 19 idle-low cycles
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            sck_q   <= 1'b0;
            idle_q  <= 5'h00;
            rises_q <= 4'h0;
        end else begin
            sck_q   <= sck;
            idle_q  <= sck ? 5'h00 : idle_q + {4'h0, idle_q != 5'h14};
            rises_q <= (idle_q == 5'h13) ? 4'h0 : rises_q + {3'h0, sck & ~sck_q};
        end
    end
    property p_byte_len; idle_q == 5'h13 |-> rises_q inside {4'h0, 4'h8}; endproperty
    property p_high_len; $rose(sck) |-> sck [*3]; endproperty
    property p_low_len; $fell(sck) |-> !sck [*3]; endproperty
    property p_mosi_hold; sck |-> $stable(mosi); endproperty
    property p_miso_hold; sck && !ss_n |-> $stable(miso); endproperty
    property p_sel_first; $rose(sck) |-> !ss_n; endproperty
    property p_miso_quiet; ss_n [*8] |-> !dev_miso_oe; endproperty
    property p_one_clock; dev_sck_oe |-> !(prt_sck_oe || prt_mosi_oe || dev_miso_oe); endproperty
    a_byte_len: assert property (p_byte_len) else $error("burst not eight clocks");
    a_high_len: assert property (p_high_len) else $error("clock high too short");
    a_low_len: assert property (p_low_len) else $error("clock low too short");
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved in high");
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved in high");
    a_sel_first: assert property (p_sel_first) else $error("clock while deselected");
    a_miso_quiet: assert property (p_miso_quiet) else $error("miso driven unselected");
    a_one_clock: assert property (p_one_clock) else $error("pin direction clash");
    c_byte: cover property (idle_q == 5'h13 && rises_q == 4'h8);
    c_dev_clock: cover property ($rose(sck) && dev_sck_oe);
    c_prt_clock: cover property ($rose(sck) && prt_sck_oe);
endmodule : sbsp_link_properties
`default_nettype wire

//--- sim/sbsp_test.sv
// Bench: device end and partner end face each other across the link.
// Assumes one 100 MHz clock; the bench is APB master and partner user.
`timescale 1ns/100ps
`default_nettype none
module sbsp_test;
    logic        clk, rst, psel, pen, pwr, p_role, p_lsb, p_start, p_keep;
    logic [7:0]  paddr, p_tx, d0, d1, t0, t1, ctl;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire  [7:0]  p_rx;
    wire         pready, pslverr, irq, p_done, wake;
    logic [33:0] apb_q[$];
    logic [7:0]  rx_q[$];
    int          fails, cmp_count;
    sbsp_link_if sbsp_link_if_i ();
    sbsp_device_end sbsp_device_end_i (.CLOCK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq),
        .WAKE_OUT(wake), .link(sbsp_link_if_i.device));
    sbsp_partner_end #(.HALF_CYC(12)) sbsp_partner_end_i (.CLOCK_IN(clk), .SYS_RST_IN(rst),
        .CONTROLLER_ROLE_IN(p_role), .LSB_FIRST_IN(p_lsb), .START_IN(p_start),
        .TX_DATA_IN(p_tx), .KEEP_SELECT_IN(p_keep), .BUSY_OUT(), .DONE_OUT(p_done),
        .RX_DATA_OUT(p_rx), .link(sbsp_link_if_i.partner));
    sbsp_link_properties sbsp_link_properties_i (.CLOCK_IN(clk), .SYS_RST_IN(rst),
        .sck(sbsp_link_if_i.sck), .mosi(sbsp_link_if_i.mosi), .miso(sbsp_link_if_i.miso),
        .ss_n(sbsp_link_if_i.ss_n), .dev_sck_oe(sbsp_link_if_i.dev_sck_oe),
        .dev_miso_oe(sbsp_link_if_i.dev_miso_oe), .prt_sck_oe(sbsp_link_if_i.prt_sck_oe),
        .prt_mosi_oe(sbsp_link_if_i.prt_mosi_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic timeout();
        fails++;
        give_verdict();
    endtask : timeout
    task automatic cmp_apb(input logic [33:0] e);
        cmp_count++;
        if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
            fails++;
            $display("mismatch at %0t: apb got %h err %b want %h", $time, prdata, pslverr, e);
        end
    endtask : cmp_apb
    task automatic cmp_rx(input logic [7:0] e);
        cmp_count++;
        if (p_rx !== e) begin
            fails++;
            $display("mismatch at %0t: partner got %h want %h", $time, p_rx, e);
        end
    endtask : cmp_rx
    task automatic cmp_wake();
        cmp_count++;
        if (wake !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: no wake pulse with done", $time);
        end
    endtask : cmp_wake
    // Result watcher: oldest note against each completed result
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && apb_q.size() > 0)
            cmp_apb(apb_q.pop_front());
        if (p_done === 1'b1 && rx_q.size() > 0)
            cmp_rx(rx_q.pop_front());
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 50)
            timeout();
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
        apb_q.push_back({1'b0, err, 32'h0});
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb_q.push_back({1'b1, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_for(input logic on_irq);
        int n;
        for (n = 0; n < 2000; n++) begin
            @(posedge clk);
            if ((on_irq ? irq : p_done) === 1'b1)
                break;
        end
        if (n == 2000)
            timeout();
        if (on_irq)
            cmp_wake();
    endtask : wait_for
    task automatic pstart(input logic [7:0] t);
        p_tx <= t;
        p_start <= 1'b1;
        @(posedge clk);
        p_start <= 1'b0;
        @(posedge clk);
    endtask : pstart
    initial begin
        {rst, psel, pen, pwr, p_role, p_lsb, p_start, p_keep} = 8'h80;
        {paddr, p_tx, pwdata} = 48'h0;
        fails = 0;
        cmp_count = 0;
        d0 = $urandom(32'h533f5c41);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Device as controller, both bit orders, rate 4
        for (int k = 0; k < 2; k++) begin
            d0 = $urandom();
            t0 = $urandom();
            ctl = {2'b11, k[0], 1'b1, 4'h4};
            p_lsb <= k[0];
            wr(sbsp_pkg::OFS_CTRL, {24'h0, ctl});
            rd(sbsp_pkg::OFS_CTRL, {25'h0, ctl});
            pstart(t0);
            wr(sbsp_pkg::OFS_PINS, 32'h07);
            rx_q.push_back(d0);
            wr(sbsp_pkg::OFS_DATA, {24'h0, d0});
            wr(sbsp_pkg::OFS_DATA, {24'h0, ~d0});
            wait_for(1'b1);
            rd(sbsp_pkg::OFS_STATUS, 33'hc0);
            rd(sbsp_pkg::OFS_DATA, {25'h0, t0});
            rd(sbsp_pkg::OFS_STATUS, 33'h0);
            wr(sbsp_pkg::OFS_PINS, 32'h14);
        end
        // Device as peripheral, partner clocks two bytes
        {d0, d1, t0, t1} = $urandom();
        p_role <= 1'b1;
        p_lsb <= 1'b0;
        wr(sbsp_pkg::OFS_PINS, 32'h08);
        // Select pulled low while still controller with select as input
        pstart(t1);
        wait_for(1'b0);
        rd(sbsp_pkg::OFS_CTRL, 33'he4);
        rd(sbsp_pkg::OFS_STATUS, 33'h80);
        wr(sbsp_pkg::OFS_CTRL, 32'hc0);
        wr(sbsp_pkg::OFS_DATA, {24'h0, d0});
        rx_q.push_back(d0);
        pstart(t0);
        wait_for(1'b1);
        rd(sbsp_pkg::OFS_STATUS, 33'h80);
        wr(sbsp_pkg::OFS_DATA, {24'h0, d1});
        rx_q.push_back(d1);
        pstart(t1);
        wait_for(1'b1);
        rd(sbsp_pkg::OFS_DATA, {25'h0, t1});
        // Port disabled: no shift, miso idle, old byte kept
        wr(sbsp_pkg::OFS_PINS, 32'h00);
        wr(sbsp_pkg::OFS_CTRL, 32'h00);
        rx_q.push_back(8'h00);
        pstart(d0);
        wait_for(1'b0);
        rd(sbsp_pkg::OFS_STATUS, 33'h0);
        rd(sbsp_pkg::OFS_DATA, {25'h0, t1});
        // Unmapped addresses
        rd(8'h10, 33'h100000000);
        wr(8'hfc, 32'h5a, 1'b1);
        if (apb_q.size() + rx_q.size() != 0)
            fails++;
        give_verdict();
    end
endmodule : sbsp_test
`default_nettype wire
